// [verilog/blbl_bus_if.sv]
// Contract
// [R1] burst length code meaningful only while address valid is high
// [R2] burst length code is 1 for four-beat bursts; 0,2,3 never driven; the design drives 0 from reset until the first start
// [R3] ordering select is static: high sub-block order, low sequential
// [R4] each byte enable high exactly when its byte is transferred
// [R5] byte enables valid only with address valid; target ignores else
// [R6] enable bit n covers data bits 8n+7:8n on reads and writes
// [R7] address valid marks a new transaction and is always defined
// [R8] burst indicator high for line fills and write bursts only
// [R9] target ignores codes without address valid, latches at start
module blbl_bus_if import blbl_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // core side
    input wire blbl_req_s req,
    output logic req_busy,
    output logic [31:0] rd_word,
    output logic rd_word_valid,
    // static strap
    input wire logic subblock_order_select,
    // external bus
    output blbl_abus_s abus,
    output logic [31:0] write_data_bus,
    input wire logic [31:0] read_data_bus,
    input wire logic beat_done
);

blbl_state_s s_q, s_d;

// lane mask: only enabled lanes of incoming read data and outgoing write data are kept
function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
        m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
endfunction

// burst word order: sub-block flips index bits, sequential wraps mod 4
function automatic logic [1:0] burst_lane(input logic [1:0] base,
                                          input logic [1:0] beat,
                                          input logic sub);
    return sub ? (base ^ beat) : 2'(base + beat);
endfunction

// ==========================================================
// next state
always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    // strap passes two flops before use
    s_d.sblock_m = subblock_order_select;
    s_d.sblock_q = s_q.sblock_m;
    // [R1] [R5] qualifier is a one-cycle pulse
    s_d.ab.address_valid = 1'b0;
    case (s_q.st)
        BLBL_IDLE: begin
            // [R7] new transaction start
            if (req.valid) begin
                s_d.st = BLBL_ADDR;
                s_d.busy = 1'b1;
                s_d.ab.address_valid = 1'b1;
                s_d.ab.write = req.write;
                s_d.ab.addr = req.addr;
                // [R8] burst flag for bursts
                s_d.ab.burst_indicator = req.burst;
                // [R2] four-beat code
                s_d.ab.burst_length_code = BLBL_BLEN_FOUR;
                // [R4] lanes; bursts move whole words
                s_d.ab.byte_lane_enables = req.burst ? BLBL_BE_ALL : req.be;
                // lanes gated here so the output leaves a flop directly
                s_d.wdata = req.wdata & lane_mask(s_d.ab.byte_lane_enables);
                s_d.beat = 2'h0;
                s_d.base = req.addr[3:2];
            end
        end
        BLBL_ADDR, BLBL_BEAT: begin
            s_d.st = BLBL_BEAT;
            if (beat_done) begin
                // [R6] sample enabled read lanes only
                s_d.rdata = read_data_bus & lane_mask(s_q.ab.byte_lane_enables);
                s_d.rvalid = ~s_q.ab.write;
                if (!s_q.ab.burst_indicator || s_q.beat == BLBL_BEAT_LAST) begin
                    s_d.st = BLBL_IDLE;
                    s_d.busy = 1'b0;
                    s_d.ab.burst_indicator = 1'b0;
                end else begin
                    s_d.beat = s_q.beat + 2'h1;
                    // [R3] sub-block xor vs sequential add
                    s_d.ab.addr[3:2] = burst_lane(s_q.base, s_d.beat,
                                                  s_q.sblock_q);
                end
            end
        end
        default: s_d.st = BLBL_IDLE;
    endcase
end

// ==========================================================
// registers
always_ff @(posedge mclk) begin
    if (sys_rst) begin
        s_q <= '0;
        s_q.st <= BLBL_IDLE;
    end else begin
        s_q <= s_d;
    end
end

assign abus = s_q.ab;
assign req_busy = s_q.busy;
assign rd_word = s_q.rdata;
assign rd_word_valid = s_q.rvalid;
// [R6] drive only enabled write lanes
assign write_data_bus = s_q.wdata;

// ==========================================================
// checks
property p_blen;
    @(posedge mclk) disable iff (sys_rst)
    abus.address_valid |-> abus.burst_length_code == BLBL_BLEN_FOUR;
endproperty
a_blen: assert property (p_blen) else $error("bad burst code"); // [R2]

property p_av_defined;
    @(posedge mclk) disable iff (sys_rst)
    req.valid && !req_busy |=> abus.address_valid;
endproperty
a_av_defined: assert property (p_av_defined) else $error("no avalid"); // [R7]

property p_av_pulse;
    @(posedge mclk) disable iff (sys_rst)
    abus.address_valid |=> !abus.address_valid;
endproperty
a_av_pulse: assert property (p_av_pulse) else $error("avalid held"); // [R1]

property p_be_burst;
    @(posedge mclk) disable iff (sys_rst)
    abus.address_valid && abus.burst_indicator |->
        abus.byte_lane_enables == BLBL_BE_ALL;
endproperty
a_be_burst: assert property (p_be_burst) else $error("burst lanes"); // [R4]

property p_be_single;
    @(posedge mclk) disable iff (sys_rst)
    req.valid && !req_busy && !req.burst |=>
        abus.byte_lane_enables == $past(req.be);
endproperty
a_be_single: assert property (p_be_single) else $error("lanes"); // [R5]

property p_burst_flag;
    @(posedge mclk) disable iff (sys_rst)
    req.valid && !req_busy |=> abus.burst_indicator == $past(req.burst);
endproperty
a_burst_flag: assert property (p_burst_flag) else $error("burst flag"); // [R8]

property p_wlanes;
    @(posedge mclk) disable iff (sys_rst)
    (write_data_bus & ~lane_mask(abus.byte_lane_enables)) == 32'h0;
endproperty
a_wlanes: assert property (p_wlanes) else $error("write lanes"); // [R6]

property p_order;
    @(posedge mclk) disable iff (sys_rst)
    s_q.st == BLBL_BEAT && beat_done && s_q.sblock_q && abus.burst_indicator
    && s_q.beat != BLBL_BEAT_LAST |=>
        abus.addr[3:2] == (s_q.base ^ s_q.beat);
endproperty
a_order: assert property (p_order) else $error("subblock order"); // [R3]

property p_seq_order;
    @(posedge mclk) disable iff (sys_rst)
    s_q.st == BLBL_BEAT && beat_done && !s_q.sblock_q && abus.burst_indicator
    && s_q.beat != BLBL_BEAT_LAST |=>
        abus.addr[3:2] == 2'(s_q.base + s_q.beat);
endproperty
a_seq_order: assert property (p_seq_order) else $error("seq order"); // [R3]

property p_first_beat;
    @(posedge mclk) disable iff (sys_rst)
    abus.address_valid |->
        s_q.beat == 2'h0 && abus.addr[3:2] == s_q.base;
endproperty
a_first_beat: assert property (p_first_beat) else $error("first"); // [R3]

property p_rvalid;
    @(posedge mclk) disable iff (sys_rst)
    req_busy && beat_done && !abus.write |=> rd_word_valid;
endproperty
a_rvalid: assert property (p_rvalid) else $error("no read word"); // [R6]

property p_wr_quiet;
    @(posedge mclk) disable iff (sys_rst)
    abus.write |=> !rd_word_valid;
endproperty
a_wr_quiet: assert property (p_wr_quiet) else $error("rd on write"); // [R6]

property p_rd_lanes;
    @(posedge mclk) disable iff (sys_rst)
    rd_word_valid |->
        (rd_word & ~lane_mask(abus.byte_lane_enables)) == 32'h0;
endproperty
a_rd_lanes: assert property (p_rd_lanes) else $error("read lanes"); // [R6]

property p_busy_av;
    @(posedge mclk) disable iff (sys_rst)
    abus.address_valid |-> req_busy && abus.write == $past(req.write);
endproperty
a_busy_av: assert property (p_busy_av) else $error("start fields"); // [R7]

property p_busy_release;
    @(posedge mclk) disable iff (sys_rst)
    req_busy && beat_done && (!abus.burst_indicator ||
        s_q.beat == BLBL_BEAT_LAST) |=> !req_busy;
endproperty
a_busy_release: assert property (p_busy_release) else $error("end"); // [R8]

property p_burst_hold;
    @(posedge mclk) disable iff (sys_rst)
    req_busy && beat_done && abus.burst_indicator &&
        s_q.beat != BLBL_BEAT_LAST |=> req_busy;
endproperty
a_burst_hold: assert property (p_burst_hold) else $error("short"); // [R2]

c_single: cover property (@(posedge mclk) abus.address_valid &&
    !abus.burst_indicator);
c_burst: cover property (@(posedge mclk) abus.address_valid &&
    abus.burst_indicator);
c_read: cover property (@(posedge mclk) rd_word_valid);
c_write: cover property (@(posedge mclk) abus.address_valid && abus.write);
c_subblock: cover property (@(posedge mclk) s_q.sblock_q &&
    abus.address_valid && abus.burst_indicator);

endmodule

// [verilog/blbl_pkg.sv]
package blbl_pkg;

// ==========================================================
// burst and lane encodings
localparam logic [1:0] BLBL_BLEN_FOUR = 2'h1;
localparam logic [1:0] BLBL_BLEN_RST = 2'h0;
localparam logic [1:0] BLBL_BEAT_LAST = 2'h3;
localparam logic [3:0] BLBL_BE_ALL = 4'hf;
localparam logic [3:0] BLBL_BE_RST = 4'h0;
localparam logic [31:0] BLBL_WORD_RST = 32'h0;

typedef enum logic [1:0] {
    BLBL_IDLE,
    BLBL_ADDR,
    BLBL_BEAT
} blbl_state_e;

// core-side request
typedef struct packed {
    logic valid;
    logic write;
    logic burst;
    logic [31:2] addr;
    logic [3:0] be;
    logic [31:0] wdata;
} blbl_req_s;

// bus-side address phase outputs
typedef struct packed {
    logic address_valid;
    logic write;
    logic burst_indicator;
    logic [1:0] burst_length_code;
    logic [3:0] byte_lane_enables;
    logic [31:2] addr;
} blbl_abus_s;

typedef struct packed {
    blbl_state_e st;
    blbl_abus_s ab;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic rvalid;
    logic [1:0] beat;
    logic [1:0] base;
    logic sblock_m;
    logic sblock_q;
    logic busy;
} blbl_state_s;

endpackage

// [tb/blbl_target_model.sv]
// ==========================================================
// far-side bus target with adjustable beat spacing
module blbl_target_model import blbl_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // bus from the core, beat spacing from the test
    input wire blbl_abus_s abus,
    input wire logic [2:0] wait_cycles,
    // answer
    output logic [31:0] read_data_bus,
    output logic beat_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] left_q;
    logic [2:0] cnt_q;
    logic [7:0] tag;
    assign tag = {6'h28, abus.addr[3:2]};
    // idle bus shows the inverse so a stale sample cannot match
    assign read_data_bus = beat_done ? {4{tag}} : ~{4{tag}};
    always_ff @(posedge mclk) begin
        beat_done <= 1'b0;
        if (sys_rst) begin
            left_q <= 3'h0;
            cnt_q <= 3'h0;
        end else if (abus.address_valid) begin
            left_q <= abus.burst_indicator ? 3'h4 : 3'h1;
            cnt_q <= wait_cycles;
        end else if (left_q != 3'h0) begin
            if (cnt_q == 3'h0) begin
                beat_done <= 1'b1;
                left_q <= left_q - 3'h1;
                cnt_q <= wait_cycles;
            end else begin
                cnt_q <= cnt_q - 3'h1;
            end
        end
    end
endmodule

// [tb/test_burst_length_byte_lane_signaling.sv]
module test_burst_length_byte_lane_signaling import blbl_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, sys_rst = 1, sb = 0, busy, rv, bd;
    logic [2:0] wt = 3'h0;
    logic [31:0] rw, wd, rd;
    blbl_req_s req = '0;
    blbl_abus_s ab;
    int bad_count = 0;
    int n_checks = 0;
    always #4 mclk = ~mclk;
    blbl_bus_if dut (.mclk(mclk), .sys_rst(sys_rst), .req(req),
        .req_busy(busy), .rd_word(rw), .rd_word_valid(rv),
        .subblock_order_select(sb), .abus(ab), .write_data_bus(wd),
        .read_data_bus(rd), .beat_done(bd));
    blbl_target_model far (.mclk(mclk), .sys_rst(sys_rst), .abus(ab),
        .wait_cycles(wt), .read_data_bus(rd), .beat_done(bd));
    task automatic chk(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic rst;
        sys_rst = 1'b1;
        repeat (20) @(negedge mclk);
        sys_rst = 1'b0;
    endtask
    task automatic txn(input logic w, b, input logic [1:0] base,
                       input logic [3:0] be);
        logic [3:0] m;
        logic [31:0] lm, av_got, av_exp, rd_exp;
        logic [2:0] k;
        logic [1:0] lane;
        m = b ? BLBL_BE_ALL : be;
        lm = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
        k = 3'h0;
        req = '{1'b1, w, b, {28'h0, base}, be, 32'h5a6b7c8d};
        @(negedge mclk);
        req.valid = 1'b0;
        av_got = 32'({ab.address_valid, ab.write, ab.burst_indicator,
                      ab.burst_length_code, ab.byte_lane_enables});
        av_exp = 32'({1'b1, w, b, BLBL_BLEN_FOUR, m});
        chk(av_got, av_exp);
        chk(32'(ab.addr), 32'({28'h0, base}));
        if (w) chk(wd, 32'h5a6b7c8d & lm);
        @(negedge mclk);
        chk(32'(ab.address_valid), 32'h0);
        repeat (40) begin
            if (rv) begin
                lane = sb ? base ^ k[1:0] : base + k[1:0];
                rd_exp = {4{6'h28, lane}} & lm;
                chk(rw, rd_exp);
                k++;
            end
            if (!busy && k == (w ? 3'h0 : b ? 3'h4 : 3'h1)) break;
            @(negedge mclk);
        end
        chk(32'(k), w ? 32'h0 : b ? 32'h4 : 32'h1);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_single;
        txn(1'b0, 1'b0, 2'h1, 4'h5);
        txn(1'b1, 1'b0, 2'h2, 4'ha);
    endtask
    task automatic t_burst_seq;
        wt = 3'h2;
        txn(1'b0, 1'b1, 2'h2, 4'h0);
        wt = 3'h0;
        txn(1'b1, 1'b1, 2'h3, 4'h0);
    endtask
    task automatic t_burst_sub;
        sb = 1'b1;
        rst;
        txn(1'b0, 1'b1, 2'h3, 4'h0);
        wt = 3'h1;
        txn(1'b0, 1'b1, 2'h1, 4'h0);
    endtask
    initial begin
        #20000;
        bad_count++;
        end_of_test;
    end
    initial begin
        rst;
        t_single;
        t_burst_seq;
        t_burst_sub;
        end_of_test;
    end
endmodule
